//--- inc/ocsw_map.svh
// constants of the octal switch channel control: offsets, resets, times
// assumes one 100 MHz clock and an 8-bit register port
// Operation
// RL1 - output is parallel OR/AND serial bit
// RL2 - AND/OR chosen per channel, eight channels
// RL3 - serial on is one; pins follow polarity
// RL4 - mappable input drives any set of channels; the code uses map bits 7:3 only and ignores map bits 2:0
// RL5 - mapping defaults to channel 4 only
// RL6 - per-channel slow or fast slew select
// RL7 - overtemperature turns channel off, records fault
// RL8 - per-channel auto-restart or latching overtemperature
// RL9 - auto-restart resumes when cool, input on
// RL10 - latching waits for new input rise
// RL11 - overtemperature only seen while channel on
// RL12 - reset pin low: outputs off, diagnosis off
// RL13 - sleep clears diagnosis and serial commands
// RL14 - after wake only parallel-driven channels on
// RL15 - limit-only mode flags overload after filter
// RL16 - limit-only mode never shuts channel down
// RL17 - shutdown mode turns off after delay
// RL18 - overload latch clears on input rise
// RL19 - host spaces write frames, 200 us; the bench sends writes as little as two cycles apart
// RL20 - faults per channel readable by host
// RL21 - polarity high: pins high active
// RL22 - fault pin low on any channel error
// RL23 - filter and switch-off are clock counters
// RL24 - pins synchronised before use
`ifndef OCSW_MAP_SVH
`define OCSW_MAP_SVH

`define OCSW_NCH 8
`define OCSW_SW 22
// bit positions in the synchronised pin vector
`define OCSW_B_PIN 0
`define OCSW_B_POL 4
`define OCSW_B_RSTP 5
`define OCSW_B_OT 6
`define OCSW_B_LIM 14

// register addresses
`define OCSW_A_MAP 4'h1
`define OCSW_A_BOL 4'h2
`define OCSW_A_OVL 4'h3
`define OCSW_A_OVT 4'h4
`define OCSW_A_SLE 4'h5
`define OCSW_A_STA 4'h6
`define OCSW_A_CTL 4'h7
`define OCSW_A_DOT 4'h8
`define OCSW_A_DOL 4'h9

// reset values
`define OCSW_MAP_RST 8'h08
`define OCSW_REG_RST 8'h00

// timing
`define OCSW_CLK_MHZ 100
`define OCSW_SLOW_US 60
`define OCSW_FAST_US 15
`define OCSW_SLOW_CYC (`OCSW_SLOW_US * `OCSW_CLK_MHZ)
`define OCSW_FAST_CYC (`OCSW_FAST_US * `OCSW_CLK_MHZ)
`define OCSW_FRAME_GAP_US 200
`define OCSW_FILT_CYC 16'h03E8
`define OCSW_OFF_CYC 16'h07D0

`endif

//--- inc/ocsw_pkg.sv
// types of the octal switch channel control
// assumes ocsw_map.svh on the include path
`include "ocsw_map.svh"

package ocsw_pkg;

   typedef struct packed {
      logic [`OCSW_SW-1:0] s1;
      logic [`OCSW_SW-1:0] s2;
      logic [`OCSW_SW-1:0] s3;
      logic [`OCSW_SW-1:0] filt;
      logic [7:0] map;
      logic [7:0] bol;
      logic [7:0] ovl;
      logic [7:0] ovt;
      logic [7:0] sle;
      logic [7:0] ctl;
      logic [7:0] eff_prev;
      logic [7:0] ot_diag;
      logic [7:0] ol_diag;
      logic [7:0] ot_lat;
      logic [7:0] ol_lat;
      logic [7:0] out;
      logic [7:0][15:0] cnt;
      logic [7:0] rdata;
      logic fault;
   } ocsw_state_type;

endpackage

//--- design/ocsw_ctrl.sv
// per-channel control of an eight-channel low-side switch
// assumes analog sense inputs and pins are asynchronous to CLK,
// and a register master on CLK with one-cycle read latency
`timescale 1ns/1ps
`include "ocsw_map.svh"

module ocsw_ctrl
   import ocsw_pkg::*;
#(
   parameter logic [15:0] FILT_CYC = `OCSW_FILT_CYC,
   parameter logic [15:0] OFF_CYC = `OCSW_OFF_CYC
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // pins
   input wire logic [3:0] PAR_IN,
   input wire logic INPUT_POLARITY_SELECT,
   input wire logic SLEEP_N,
   // analog sense per channel
   input wire logic [7:0] OT_SENSE,
   input wire logic [7:0] LIMIT_SENSE,
   // channel drive
   output logic [7:0] CH_ON,
   output logic [7:0] SLEW_FAST,
   // open-drain fault flag
   output logic FAULT_O,
   output logic FAULT_OE
);

   ocsw_state_type st;
   ocsw_state_type next_st;

   logic [`OCSW_SW-1:0] pins;
   logic awake;
   logic pol;
   logic [3:0] act;
   logic [7:0] par;
   logic [7:0] eff;
   logic [7:0] rise;
   logic [7:0] ot_in;
   logic [7:0] lim_in;

   assign pins = {LIMIT_SENSE, OT_SENSE, SLEEP_N,
      INPUT_POLARITY_SELECT, PAR_IN};
   assign awake = st.filt[`OCSW_B_RSTP];
   assign pol = st.filt[`OCSW_B_POL];
   assign ot_in = st.filt[`OCSW_B_OT +: 8];
   assign lim_in = st.filt[`OCSW_B_LIM +: 8];

   // RL3 RL21 pin polarity
   assign act = pol ? st.filt[`OCSW_B_PIN +: 4] :
      ~st.filt[`OCSW_B_PIN +: 4];

   // RL4 mappable input fan-out
   assign par = {st.map[7:3] & {5{act[3]}}, act[2:0]};

   // RL1 RL2 per-channel combination
   assign eff = (st.bol & par & st.ctl) | (~st.bol & (par | st.ctl));
   assign rise = eff & ~st.eff_prev;

   always_comb
   begin
      next_st = st;
      // RL24 three-stage pin capture, agreeing stages only
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int b = 0; b < `OCSW_SW; b++)
      begin
         if (st.s2[b] == st.s3[b])
         begin
            next_st.filt[b] = st.s3[b];
         end
      end
      next_st.eff_prev = eff;

      // RL20 read mux, diagnosis cleared by its read
      next_st.rdata = 8'h00;
      if (RD)
      begin
         unique case (ADDR)
            `OCSW_A_MAP: next_st.rdata = st.map;
            `OCSW_A_BOL: next_st.rdata = st.bol;
            `OCSW_A_OVL: next_st.rdata = st.ovl;
            `OCSW_A_OVT: next_st.rdata = st.ovt;
            `OCSW_A_SLE: next_st.rdata = st.sle;
            `OCSW_A_STA: next_st.rdata = st.out;
            `OCSW_A_CTL: next_st.rdata = st.ctl;
            `OCSW_A_DOT:
            begin
               next_st.rdata = st.ot_diag;
               next_st.ot_diag = 8'h00;
            end
            `OCSW_A_DOL:
            begin
               next_st.rdata = st.ol_diag;
               next_st.ol_diag = 8'h00;
            end
            default: next_st.rdata = 8'h00;
         endcase
      end

      if (WR)
      begin
         unique case (ADDR)
            `OCSW_A_MAP: next_st.map = WDATA;
            `OCSW_A_BOL: next_st.bol = WDATA;
            `OCSW_A_OVL: next_st.ovl = WDATA;
            `OCSW_A_OVT: next_st.ovt = WDATA;
            `OCSW_A_SLE: next_st.sle = WDATA;
            `OCSW_A_CTL: next_st.ctl = WDATA;
            default: next_st.ctl = next_st.ctl;
         endcase
      end

      for (int i = 0; i < `OCSW_NCH; i++)
      begin
         // RL23 limitation duration counter
         if (lim_in[i] && st.out[i])
         begin
            if (st.cnt[i] != 16'hFFFF)
            begin
               next_st.cnt[i] = st.cnt[i] + 16'h0001;
            end
         end
         else
         begin
            next_st.cnt[i] = 16'h0000;
         end

         // RL18 input rise releases overload latch
         if (rise[i])
         begin
            next_st.ol_lat[i] = 1'b0;
         end
         // RL16 limit-only mode never holds a latch
         if (!st.ovl[i])
         begin
            next_st.ol_lat[i] = 1'b0;
         end
         // RL15 limit-only fault after filter time
         if (!st.ovl[i] && st.cnt[i] >= FILT_CYC)
         begin
            next_st.ol_diag[i] = 1'b1;
         end
         // RL17 shutdown after switch-off delay
         // at or past, so a later mode change still trips
         if (st.ovl[i] && st.cnt[i] >= OFF_CYC)
         begin
            next_st.ol_diag[i] = 1'b1;
            next_st.ol_lat[i] = 1'b1;
         end

         // RL8 RL9 auto-restart clears once cooled
         if (!st.ovt[i] && !ot_in[i])
         begin
            next_st.ot_lat[i] = 1'b0;
         end
         // RL10 latching clears on rise when cool
         if (st.ovt[i] && rise[i] && !ot_in[i])
         begin
            next_st.ot_lat[i] = 1'b0;
         end
         // RL7 RL11 sensor counts only while on
         if (ot_in[i] && st.out[i])
         begin
            next_st.ot_lat[i] = 1'b1;
            next_st.ot_diag[i] = 1'b1;
         end
      end

      // RL1 drive from combination minus protection
      next_st.out = eff & ~st.ot_lat & ~st.ol_lat;

      // RL12 RL13 RL14 sleep clears commands and faults
      if (!awake)
      begin
         next_st.out = 8'h00;
         next_st.ctl = 8'h00;
         next_st.ot_diag = 8'h00;
         next_st.ol_diag = 8'h00;
         next_st.ot_lat = 8'h00;
         next_st.ol_lat = 8'h00;
      end

      // RL22 any stored fault pulls the flag
      next_st.fault = awake && ((st.ot_diag | st.ol_diag) != 8'h00);
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st <= '0;
         // RL5 mapping default
         st.map <= `OCSW_MAP_RST;
         st.bol <= `OCSW_REG_RST;
         st.ovl <= `OCSW_REG_RST;
         st.ovt <= `OCSW_REG_RST;
         st.sle <= `OCSW_REG_RST;
         st.ctl <= `OCSW_REG_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign RDATA = st.rdata;
   assign CH_ON = st.out;
   // RL6 slew select straight from the register
   assign SLEW_FAST = st.sle;
   assign FAULT_O = 1'b0;
   assign FAULT_OE = st.fault;

   // checking helpers
   logic [7:0] want;
   logic [7:0] and_blk;
   logic [7:0] ot_hit;
   logic [7:0] ol_due;
   logic [7:0] ol_filt;
   logic [7:0] ot_cool;
   logic [7:0] ot_keep;
   logic [7:0] ot_idle;
   logic [7:0] ol_free;
   logic [7:0] rise_q;
   logic [7:0] lat_q;
   logic diag_any;
   logic awake_q;

   assign and_blk = st.bol & ~st.ctl;
   assign ot_hit = ot_in & st.out;
   assign ol_free = ~st.ovl;
   assign diag_any = (st.ot_diag | st.ol_diag) != 8'h00;
   assign ot_cool = st.ot_lat & ~st.ovt & ~ot_in;
   assign ot_keep = st.ot_lat & st.ovt & ~rise;
   assign ot_idle = ot_in & ~st.out & ~st.ot_diag;

   // reference from the truth table, not from eff
   for (genvar g = 0; g < `OCSW_NCH; g++)
   begin : g_ref
      assign want[g] = (st.bol[g] ? (par[g] && st.ctl[g]) :
         (par[g] || st.ctl[g])) && !st.ot_lat[g] && !st.ol_lat[g];
      assign ol_due[g] = st.ovl[g] && lim_in[g] && st.out[g] &&
         (st.cnt[g] >= OFF_CYC);
      assign ol_filt[g] = !st.ovl[g] && lim_in[g] && st.out[g] &&
         (st.cnt[g] >= FILT_CYC);
   end

   always_ff @(posedge CLK)
   begin
      rise_q <= rise;
      lat_q <= st.ol_lat;
      awake_q <= awake;
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   property p_bool;
      awake |=> st.out == $past(want);
   endproperty
   a_bool: assert property (p_bool) // RL1
      else $error("output differs from combination");

   property p_and;
      (awake && and_blk != 8'h00) |=> (st.out & $past(and_blk)) == 8'h00;
   endproperty
   a_and: assert property (p_and) // RL2
      else $error("and channel on without serial bit");

   property p_map;
      $past(RST) |-> st.map == `OCSW_MAP_RST;
   endproperty
   a_map: assert property (p_map) // RL5
      else $error("mapping not at default after reset");

   property p_ot;
      (awake && ot_hit != 8'h00) |=>
         ((st.ot_lat & st.ot_diag & $past(ot_hit)) == $past(ot_hit))
         ##1 ((st.out & $past(ot_hit, 2)) == 8'h00);
   endproperty
   a_ot: assert property (p_ot) // RL7
      else $error("overtemperature did not latch and switch off");

   property p_sleep;
      !awake |=> st.out == 8'h00 && st.ctl == 8'h00 &&
         st.ot_diag == 8'h00 && st.ol_diag == 8'h00;
   endproperty
   a_sleep: assert property (p_sleep) // RL13
      else $error("sleep left state behind");

   property p_noshut;
      ##1 (st.ol_lat & $past(ol_free)) == 8'h00;
   endproperty
   a_noshut: assert property (p_noshut) // RL16
      else $error("limit-only channel latched off");

   property p_shut;
      (awake && ol_due != 8'h00) |=>
         (st.ol_lat & st.ol_diag & $past(ol_due)) == $past(ol_due);
   endproperty
   a_shut: assert property (p_shut) // RL17
      else $error("overload shutdown missing");

   property p_release;
      (awake && awake_q) |-> ((lat_q & ~st.ol_lat & ~rise_q &
         ~$past(ol_free)) == 8'h00);
   endproperty
   a_release: assert property (p_release) // RL18
      else $error("overload latch freed without input rise");

   property p_fault;
      (awake && diag_any) |=> FAULT_OE;
   endproperty
   a_fault: assert property (p_fault) // RL22
      else $error("fault flag not raised");

   property p_filt;
      (awake && ol_filt != 8'h00) |=>
         (st.ol_diag & $past(ol_filt)) == $past(ol_filt);
   endproperty
   a_filt: assert property (p_filt) // RL15
      else $error("limit-only overload not flagged");

   property p_cool;
      (awake && ot_cool != 8'h00) |=>
         (st.ot_lat & $past(ot_cool)) == 8'h00;
   endproperty
   a_cool: assert property (p_cool) // RL9
      else $error("auto-restart latch not freed when cool");

   property p_keep;
      (awake && ot_keep != 8'h00) |=>
         (st.ot_lat & $past(ot_keep)) == $past(ot_keep);
   endproperty
   a_keep: assert property (p_keep) // RL10
      else $error("latching overtemperature freed without rise");

   property p_cold;
      (awake && ot_idle != 8'h00) |=>
         (st.ot_diag & $past(ot_idle)) == 8'h00;
   endproperty
   a_cold: assert property (p_cold) // RL11
      else $error("overtemperature recorded on an off channel");

   property p_slew;
      ($past(WR) && $past(ADDR) == `OCSW_A_SLE && !$past(RST)) |->
         SLEW_FAST == $past(WDATA);
   endproperty
   a_slew: assert property (p_slew) // RL6
      else $error("slew select does not follow its write");

   property p_wake;
      (awake && !awake_q) |-> st.ctl == 8'h00 && st.out == 8'h00;
   endproperty
   a_wake: assert property (p_wake) // RL14
      else $error("serial command survived sleep");

   property p_rdiag;
      ($past(RD) && $past(ADDR) == `OCSW_A_DOT && !$past(RST)) |->
         RDATA == $past(st.ot_diag);
   endproperty
   a_rdiag: assert property (p_rdiag) // RL20
      else $error("diagnosis read returned wrong data");

   property p_dark;
      !awake |=> !FAULT_OE;
   endproperty
   a_dark: assert property (p_dark) // RL12
      else $error("fault flag raised in sleep");

   c_ot: cover property (awake && ot_hit != 8'h00);
   c_ol: cover property (awake && st.ol_lat != 8'h00);
   c_wake: cover property (!awake ##1 awake);
   c_map: cover property (st.map == 8'hFF && act[3]);
   c_cool: cover property (awake && ot_cool != 8'h00);

endmodule // ocsw_ctrl

//--- test/ocsw_host.sv
// host pin and load model facing ocsw_ctrl
// assumes the bench sets request levels; pins move after CLK rises
`timescale 1ns/1ps
module ocsw_host
(
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic [3:0] par_req,
   input wire logic pol_req,
   input wire logic wake_req,
   input wire logic [7:0] hot_req,
   input wire logic [7:0] short_req,
   // switch side
   input wire logic [7:0] ch_on,
   output logic [3:0] par_in = 4'h0,
   output logic pol = 1'b1,
   output logic sleep_n = 1'b1,
   output logic [7:0] ot_sense = 8'h00,
   output logic [7:0] limit_sense = 8'h00
);
   always @(posedge clk)
   begin
      par_in <= par_req;
      pol <= pol_req;
      sleep_n <= wake_req;
      ot_sense <= hot_req;
      // a shorted load only limits while it is driven
      limit_sense <= short_req & ch_on;
   end
endmodule // ocsw_host

//--- test/test_ocsw_ctrl.sv
// self-checking bench of ocsw_ctrl with the host model
// assumes the register port and pins of ocsw_ctrl
`timescale 1ns/1ps
`include "ocsw_map.svh"
module test_ocsw_ctrl;
   typedef struct packed {
      logic pol;
      logic [3:0] par;
      logic [7:0] map, bol, ctl, sle, exp;
   } ocsw_row_type;
   localparam ocsw_row_type rows [6] = '{
      '{1'b1, 4'h5, 8'h08, 8'h00, 8'h00, 8'h01, 8'h05},
      '{1'b1, 4'h0, 8'h08, 8'h00, 8'hF0, 8'h80, 8'hF0},
      '{1'b1, 4'hF, 8'h08, 8'hFF, 8'h1A, 8'hFF, 8'h0A},
      '{1'b0, 4'hF, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00},
      '{1'b0, 4'h0, 8'h08, 8'h0F, 8'h03, 8'h5A, 8'h03},
      '{1'b1, 4'h8, 8'hF0, 8'h00, 8'h00, 8'h00, 8'hF0}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [3:0] par_req = 4'h0;
   logic pol_req = 1'b1;
   logic wake_req = 1'b1;
   logic [7:0] hot_req = 8'h00;
   logic [7:0] short_req = 8'h00;
   logic [7:0] rdata, ch_on, slew_fast, ot_sense, limit_sense;
   logic [3:0] par_in;
   logic pol, sleep_n, fault_o, fault_oe;
   int n_mismatch = 0;
   int checks = 0;

   always #5 clk = ~clk;

   ocsw_host host (.clk(clk), .par_req(par_req), .pol_req(pol_req),
      .wake_req(wake_req), .hot_req(hot_req), .short_req(short_req),
      .ch_on(ch_on), .par_in(par_in), .pol(pol), .sleep_n(sleep_n),
      .ot_sense(ot_sense), .limit_sense(limit_sense));

   // short counts keep the overload cases brief
   ocsw_ctrl #(.FILT_CYC(16'h0008), .OFF_CYC(16'h0010)) DUT (.CLK(clk),
      .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .PAR_IN(par_in), .INPUT_POLARITY_SELECT(pol),
      .SLEEP_N(sleep_n), .OT_SENSE(ot_sense), .LIMIT_SENSE(limit_sense),
      .CH_ON(ch_on), .SLEW_FAST(slew_fast), .FAULT_O(fault_o),
      .FAULT_OE(fault_oe));

   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask

   // pins need the synchroniser and one edge more
   task automatic on_is(input logic [7:0] e);
      repeat (14) @(posedge clk);
      #1 chk("ch_on", e, ch_on);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict;
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      for (int a = 0; a < 16; a++)
         rd(a[3:0], (a == 1) ? 8'h08 : 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      foreach (rows[i])
      begin
         par_req <= rows[i].par;
         pol_req <= rows[i].pol;
         wr(`OCSW_A_MAP, rows[i].map);
         wr(`OCSW_A_BOL, rows[i].bol);
         wr(`OCSW_A_CTL, rows[i].ctl);
         wr(`OCSW_A_SLE, rows[i].sle);
         on_is(rows[i].exp);
         chk("slew", rows[i].sle, slew_fast);
         rd(`OCSW_A_STA, rows[i].exp);
      end
      pol_req <= 1'b1;
      par_req <= 4'h0;
      wr(`OCSW_A_CTL, 8'h01);
      on_is(8'h01);
      hot_req <= 8'h03;
      on_is(8'h00);
      chk("fault_oe", 8'h01, {7'h00, fault_oe});
      chk("fault_o", 8'h00, {7'h00, fault_o});
      rd(`OCSW_A_DOT, 8'h01);
      hot_req <= 8'h00;
      on_is(8'h01);
      chk("fault_oe", 8'h00, {7'h00, fault_oe});
      wr(`OCSW_A_OVT, 8'h01);
      hot_req <= 8'h01;
      on_is(8'h00);
      hot_req <= 8'h00;
      on_is(8'h00);
      wr(`OCSW_A_CTL, 8'h00);
      wr(`OCSW_A_CTL, 8'h05);
      on_is(8'h05);
      rd(`OCSW_A_DOT, 8'h01);
      short_req <= 8'h04;
      on_is(8'h05);
      on_is(8'h05);
      rd(`OCSW_A_DOL, 8'h04);
      wr(`OCSW_A_OVL, 8'h04);
      on_is(8'h01);
      rd(`OCSW_A_DOL, 8'h04);
      short_req <= 8'h00;
      on_is(8'h01);
      wr(`OCSW_A_CTL, 8'h01);
      wr(`OCSW_A_CTL, 8'h05);
      on_is(8'h05);
      par_req <= 4'h1;
      wr(`OCSW_A_CTL, 8'h02);
      on_is(8'h03);
      hot_req <= 8'h02;
      on_is(8'h01);
      wake_req <= 1'b0;
      hot_req <= 8'h00;
      on_is(8'h00);
      chk("fault_oe", 8'h00, {7'h00, fault_oe});
      wr(`OCSW_A_CTL, 8'h04);
      wake_req <= 1'b1;
      on_is(8'h01);
      rd(`OCSW_A_CTL, 8'h00);
      rd(`OCSW_A_DOT, 8'h00);
      // mid-run reset must restore the mapping default
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 chk("ch_on", 8'h00, ch_on);
      rd(`OCSW_A_MAP, 8'h08);
      on_is(8'h01);
      print_verdict;
   end
endmodule // test_ocsw_ctrl
